// [core/pif_pkg.sv]
// Constants shared by the peripheral interrupt flag block
package pif_pkg;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [11:0] ANALOG_FLAGS_OFS = 12'h000;
    localparam logic [11:0] SERIAL_FLAGS_OFS = 12'h004;
    localparam logic [11:0] ANALOG_MASK_OFS  = 12'h008;
    localparam logic [11:0] SERIAL_MASK_OFS  = 12'h00c;
    localparam logic [11:0] ZC_CTRL_OFS      = 12'h010;

    // ========================================
    // Field positions in analog_event_flags
    localparam int ZC_BIT   = 6;
    localparam int CMP2_BIT = 1;
    localparam int CMP1_BIT = 0;

    // ========================================
    // Field positions in serial_event_flags
    localparam int RX_BIT      = 5;
    localparam int TX_BIT      = 4;
    localparam int P2_COLL_BIT = 3;
    localparam int P2_DONE_BIT = 2;
    localparam int P1_COLL_BIT = 1;
    localparam int P1_DONE_BIT = 0;

    // ========================================
    // Implemented and writable bit masks
    localparam logic [7:0] ANALOG_IMPL_MASK = 8'h43;
    localparam logic [7:0] SERIAL_IMPL_MASK = 8'h3f;
    localparam logic [7:0] SERIAL_WR_MASK   = 8'h0f;

    // ========================================
    // Zero-cross control fields
    localparam int ZC_RISE_BIT = 0;
    localparam int ZC_FALL_BIT = 1;

    // ========================================
    // Reset values
    localparam logic [7:0] FLAGS_RST   = 8'h00;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [1:0] ZC_CTRL_RST = 2'h3;

    // ========================================
    // Input lanes of the synchroniser
    localparam int IN_W       = 9;
    localparam int IN_ZC      = 0;
    localparam int IN_CMP1    = 1;
    localparam int IN_CMP2    = 2;
    localparam int IN_P1_DONE = 3;
    localparam int IN_P1_COLL = 4;
    localparam int IN_P2_DONE = 5;
    localparam int IN_P2_COLL = 6;
    localparam int IN_RX      = 7;
    localparam int IN_TX      = 8;

    // ========================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage : pif_pkg

// [core/sync_edges.sv]
// Two-flop synchroniser with edge detection, one lane per input bit
`timescale 1ns/1ps
module sync_edges #(
    parameter int WIDTH = 1
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    // ========================================
    // Per-lane synchroniser
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : lane
            logic meta_reg;
            logic sync_reg;
            logic prev_reg;

            // First flop feeds only the second one
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end else begin
                    meta_reg <= async_in[g];
                    sync_reg <= meta_reg;
                    prev_reg <= sync_reg;
                end
            end

            assign level[g] = sync_reg;
            assign rise[g]  = sync_reg & ~prev_reg;
            assign fall[g]  = ~sync_reg & prev_reg;
        end
    endgenerate

endmodule : sync_edges

// [core/peripheral_interrupt_flags.sv]
// Peripheral interrupt request flags with AHB-Lite register access
// How it works
// RULE_01: A zero-cross edge of an enabled polarity sets the sticky zero-cross flag in bit 6.
// RULE_02: A rising interrupt condition of comparator two sets bit 1 until software writes it 0.
// RULE_03: A rising interrupt condition of comparator one sets bit 0 until software writes it 0.
// RULE_04: Bits 7 and 5..2 of the analog register and bits 7..6 of the serial one read 0.
// RULE_05: Every implemented flag is cleared by reset, whatever its source.
// RULE_06: Flags are captured whatever the mask and global enable say.
// RULE_07: Software should clear a pending flag before it unmasks that source.
// RULE_08: Receive and transmit flags follow their buffer levels and ignore writes.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module peripheral_interrupt_flags (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        zero_cross_in,
    input  wire logic        comparator_one_in,
    input  wire logic        comparator_two_in,
    input  wire logic        port_one_done_in,
    input  wire logic        port_one_collision_in,
    input  wire logic        port_two_done_in,
    input  wire logic        port_two_collision_in,
    input  wire logic        receive_buffer_full_in,
    input  wire logic        transmit_buffer_ready_in,
    output logic             irq
);

    // ========================================
    // Input synchronisation
    logic [pif_pkg::IN_W-1:0] raw_in;
    logic [pif_pkg::IN_W-1:0] evt_level;
    logic [pif_pkg::IN_W-1:0] evt_rise;
    logic [pif_pkg::IN_W-1:0] evt_fall;

    assign raw_in = {transmit_buffer_ready_in, receive_buffer_full_in,
                     port_two_collision_in, port_two_done_in,
                     port_one_collision_in, port_one_done_in,
                     comparator_two_in, comparator_one_in, zero_cross_in};

    sync_edges #(
        .WIDTH (pif_pkg::IN_W)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (raw_in),
        .level    (evt_level),
        .rise     (evt_rise),
        .fall     (evt_fall)
    );

    // ========================================
    // Bus address phase
    logic        addr_ok;
    logic        wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_next;
    logic        hreadyout_reg;
    logic        hresp_reg;

    // hsize is not checked: every access acts on the whole word
    assign addr_ok = hsel & hready & (htrans == pif_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // Zero wait states, so both stay constant after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= pif_pkg::HRESP_OKAY;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= pif_pkg::HRESP_OKAY;
        end
    end

    // ========================================
    // Write strobes in the data phase
    logic wr_analog;
    logic wr_serial;
    logic wr_amask;
    logic wr_smask;
    logic wr_zc;

    assign wr_analog = wr_pend_reg && (wr_addr_reg == pif_pkg::ANALOG_FLAGS_OFS);
    assign wr_serial = wr_pend_reg && (wr_addr_reg == pif_pkg::SERIAL_FLAGS_OFS);
    assign wr_amask  = wr_pend_reg && (wr_addr_reg == pif_pkg::ANALOG_MASK_OFS);
    assign wr_smask  = wr_pend_reg && (wr_addr_reg == pif_pkg::SERIAL_MASK_OFS);
    assign wr_zc     = wr_pend_reg && (wr_addr_reg == pif_pkg::ZC_CTRL_OFS);

    // ========================================
    // Control registers
    logic [7:0] analog_mask_reg;
    logic [7:0] serial_mask_reg;
    logic [1:0] zc_ctrl_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_mask_reg <= pif_pkg::MASK_RST;
        end else if (wr_amask) begin
            analog_mask_reg <= hwdata[7:0] & pif_pkg::ANALOG_IMPL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_mask_reg <= pif_pkg::MASK_RST;
        end else if (wr_smask) begin
            serial_mask_reg <= hwdata[7:0] & pif_pkg::SERIAL_IMPL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zc_ctrl_reg <= pif_pkg::ZC_CTRL_RST;
        end else if (wr_zc) begin
            zc_ctrl_reg <= hwdata[1:0];
        end
    end

    // ========================================
    // Flag registers
    logic       zc_event;
    logic [7:0] analog_set;
    logic [7:0] analog_flags_reg;
    logic [7:0] analog_flags_next;
    logic [7:0] serial_set;
    logic [7:0] serial_flags_reg;
    logic [7:0] serial_flags_next;

    assign zc_event = (evt_rise[pif_pkg::IN_ZC] & zc_ctrl_reg[pif_pkg::ZC_RISE_BIT])
                    | (evt_fall[pif_pkg::IN_ZC] & zc_ctrl_reg[pif_pkg::ZC_FALL_BIT]); // RULE_01

    // Masks play no part in capture
    always_comb begin
        analog_set = 8'h00;
        analog_set[pif_pkg::ZC_BIT]   = zc_event;                      // RULE_01 RULE_06
        analog_set[pif_pkg::CMP2_BIT] = evt_rise[pif_pkg::IN_CMP2];    // RULE_02 RULE_06
        analog_set[pif_pkg::CMP1_BIT] = evt_rise[pif_pkg::IN_CMP1];    // RULE_03 RULE_06
        analog_flags_next = analog_flags_reg;
        if (wr_analog) begin
            analog_flags_next = hwdata[7:0];
        end
        // Set wins over a clearing write in the same cycle
        analog_flags_next = (analog_flags_next | analog_set)
                          & pif_pkg::ANALOG_IMPL_MASK;                 // RULE_04
    end

    always_comb begin
        serial_set = 8'h00;
        serial_set[pif_pkg::P2_COLL_BIT] = evt_rise[pif_pkg::IN_P2_COLL];   // RULE_06
        serial_set[pif_pkg::P2_DONE_BIT] = evt_rise[pif_pkg::IN_P2_DONE];   // RULE_06
        serial_set[pif_pkg::P1_COLL_BIT] = evt_rise[pif_pkg::IN_P1_COLL];   // RULE_06
        serial_set[pif_pkg::P1_DONE_BIT] = evt_rise[pif_pkg::IN_P1_DONE];   // RULE_06
        serial_flags_next = serial_flags_reg;
        if (wr_serial) begin
            serial_flags_next = hwdata[7:0];
        end
        serial_flags_next = (serial_flags_next | serial_set) & pif_pkg::SERIAL_WR_MASK;
        // Buffer levels overwrite whatever was written
        serial_flags_next[pif_pkg::RX_BIT] = evt_level[pif_pkg::IN_RX];    // RULE_08
        serial_flags_next[pif_pkg::TX_BIT] = evt_level[pif_pkg::IN_TX];    // RULE_08
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_flags_reg <= pif_pkg::FLAGS_RST;                    // RULE_05
        end else begin
            analog_flags_reg <= analog_flags_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_flags_reg <= pif_pkg::FLAGS_RST;                    // RULE_05
        end else begin
            serial_flags_reg <= serial_flags_next;
        end
    end

    // ========================================
    // Read data, captured in the address phase
    always_comb begin
        rd_next = 32'h0000_0000;
        if (haddr == pif_pkg::ANALOG_FLAGS_OFS) begin
            rd_next[7:0] = analog_flags_reg;                           // RULE_04
        end else if (haddr == pif_pkg::SERIAL_FLAGS_OFS) begin
            rd_next[7:0] = serial_flags_reg;                           // RULE_04
        end else if (haddr == pif_pkg::ANALOG_MASK_OFS) begin
            rd_next[7:0] = analog_mask_reg;
        end else if (haddr == pif_pkg::SERIAL_MASK_OFS) begin
            rd_next[7:0] = serial_mask_reg;
        end else if (haddr == pif_pkg::ZC_CTRL_OFS) begin
            rd_next[1:0] = zc_ctrl_reg;
        end else begin
            rd_next = 32'h0000_0000;
        end
    end

    // A read right behind a write to the same word sees the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_reg <= rd_next;
        end else begin
            hrdata_reg <= 32'h0000_0000;
        end
    end

    // ========================================
    // Interrupt output
    logic irq_reg;
    logic pending;

    // Unmasking a stale flag raises irq at once; software clears first
    assign pending = |((analog_flags_reg & analog_mask_reg)
                     | (serial_flags_reg & serial_mask_reg));          // RULE_07

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= pending;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;
    assign irq       = irq_reg;

    // ========================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    zero_cross_set_a: assert property ( // RULE_01
        zc_event |=> analog_flags_reg[pif_pkg::ZC_BIT])
        else $error("zero-cross event did not set its flag");

    zc_edge_gate_a: assert property ( // RULE_01
        (evt_rise[pif_pkg::IN_ZC] && !zc_ctrl_reg[pif_pkg::ZC_RISE_BIT]
         && !analog_flags_reg[pif_pkg::ZC_BIT] && !wr_analog)
        |=> !analog_flags_reg[pif_pkg::ZC_BIT])
        else $error("disabled zero-cross edge set the flag");

    cmp_two_set_a: assert property ( // RULE_02
        evt_rise[pif_pkg::IN_CMP2] |=> analog_flags_reg[pif_pkg::CMP2_BIT])
        else $error("comparator two event did not set its flag");

    cmp_one_set_a: assert property ( // RULE_03
        $rose(evt_level[pif_pkg::IN_CMP1]) |=> analog_flags_reg[pif_pkg::CMP1_BIT])
        else $error("comparator one event did not set its flag");

    flag_hold_a: assert property ( // RULE_03
        (analog_flags_reg[pif_pkg::CMP1_BIT] && !wr_analog) [*3]
        |=> analog_flags_reg[pif_pkg::CMP1_BIT])
        else $error("comparator one flag dropped without a write");

    flag_clear_a: assert property ( // RULE_02
        (wr_analog && !hwdata[pif_pkg::CMP2_BIT] && !evt_rise[pif_pkg::IN_CMP2])
        |=> !analog_flags_reg[pif_pkg::CMP2_BIT])
        else $error("writing zero did not clear comparator two flag");

    reserved_zero_a: assert property ( // RULE_04
        (analog_flags_reg & ~pif_pkg::ANALOG_IMPL_MASK) == 8'h00
        && serial_flags_reg[7:6] == 2'h0 && hrdata_reg[31:8] == 24'h000000)
        else $error("unimplemented bit reads as one");

    reset_clear_a: assert property ( // RULE_05
        @(posedge hclk) disable iff (1'b0)
        $rose(hresetn) |-> (analog_flags_reg == 8'h00 && serial_flags_reg == 8'h00))
        else $error("flags not cleared by reset");

    // Serial masks and mask writes must be quiet too, or irq may rise legally
    mask_free_a: assert property ( // RULE_06
        (analog_mask_reg == 8'h00 && serial_mask_reg == 8'h00 && !wr_amask && !wr_smask
         && evt_rise[pif_pkg::IN_CMP2])
        |=> analog_flags_reg[pif_pkg::CMP2_BIT] ##1 !irq)
        else $error("masked event was not captured or raised irq");

    rx_level_a: assert property ( // RULE_08
        serial_flags_reg[pif_pkg::RX_BIT] == $past(evt_level[pif_pkg::IN_RX])
        && serial_flags_reg[pif_pkg::TX_BIT] == $past(evt_level[pif_pkg::IN_TX]))
        else $error("buffer flag does not follow its level");

    irq_follow_a: assert property (
        pending |=> irq)
        else $error("unmasked flag did not raise irq");

    irq_quiet_a: assert property (
        !pending |=> !irq)
        else $error("irq high with no unmasked flag");

    // ========================================
    // Serial flags, zero-cross falling edge gate, masks and bus answer
    serial_set_a: assert property ( // RULE_06
        evt_rise[pif_pkg::IN_P1_DONE] |=> serial_flags_reg[pif_pkg::P1_DONE_BIT])
        else $error("port one done event did not set its flag");

    serial_clear_a: assert property (
        (wr_serial && !hwdata[pif_pkg::P2_COLL_BIT] && !evt_rise[pif_pkg::IN_P2_COLL])
        |=> !serial_flags_reg[pif_pkg::P2_COLL_BIT])
        else $error("writing zero did not clear port two collision flag");

    zc_fall_gate_a: assert property ( // RULE_01
        (evt_fall[pif_pkg::IN_ZC] && !zc_ctrl_reg[pif_pkg::ZC_FALL_BIT]
         && !analog_flags_reg[pif_pkg::ZC_BIT] && !wr_analog)
        |=> !analog_flags_reg[pif_pkg::ZC_BIT])
        else $error("disabled zero-cross falling edge set the flag");

    mask_impl_a: assert property (
        (analog_mask_reg & ~pif_pkg::ANALOG_IMPL_MASK) == 8'h00
        && serial_mask_reg[7:6] == 2'h0)
        else $error("unimplemented mask bit is set");

    bus_okay_a: assert property (
        hreadyout && hresp == pif_pkg::HRESP_OKAY)
        else $error("bus answered with a wait state or an error");

    read_idle_zero_a: assert property (
        !(addr_ok && !hwrite) |=> hrdata == 32'h0000_0000)
        else $error("read data not zero outside a read data phase");

    zc_set_c:   cover property (zc_event ##1 analog_flags_reg[pif_pkg::ZC_BIT]);
    irq_rise_c: cover property ($rose(irq));
    clear_c:    cover property (wr_analog ##1 analog_flags_reg == 8'h00);
    rx_c:       cover property ($rose(serial_flags_reg[pif_pkg::RX_BIT]));
    coll_c:     cover property (evt_rise[pif_pkg::IN_P2_COLL] ##1 serial_flags_reg[3]);

endmodule : peripheral_interrupt_flags

// [bench/tb_top.sv]
// Self-checking testbench for the peripheral interrupt flag block
`timescale 1ns/1ps
module tb_top;
    // ========================================
    // Clock, reset and port signals
    logic                      hclk;
    logic                      hresetn;
    logic                      hsel;
    logic [11:0]               haddr;
    logic [1:0]                htrans;
    logic                      hwrite;
    logic [2:0]                hsize;
    logic [31:0]               hwdata;
    logic [31:0]               hrdata;
    logic                      hready;
    logic                      hresp;
    logic                      irq;
    logic [pif_pkg::IN_W-1:0]  ev;
    int                        n_fail;
    int                        n_tests;

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    peripheral_interrupt_flags uut (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (hsize),
        .hready                   (hready),
        .hwdata                   (hwdata),
        .hrdata                   (hrdata),
        .hreadyout                (hready),
        .hresp                    (hresp),
        .zero_cross_in            (ev[pif_pkg::IN_ZC]),
        .comparator_one_in        (ev[pif_pkg::IN_CMP1]),
        .comparator_two_in        (ev[pif_pkg::IN_CMP2]),
        .port_one_done_in         (ev[pif_pkg::IN_P1_DONE]),
        .port_one_collision_in    (ev[pif_pkg::IN_P1_COLL]),
        .port_two_done_in         (ev[pif_pkg::IN_P2_DONE]),
        .port_two_collision_in    (ev[pif_pkg::IN_P2_COLL]),
        .receive_buffer_full_in   (ev[pif_pkg::IN_RX]),
        .transmit_buffer_ready_in (ev[pif_pkg::IN_TX]),
        .irq                      (irq)
    );

    // ========================================
    // Verdict and compare tasks
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check8

    task automatic check_irq(input logic exp);
        n_tests++;
        if (irq !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: irq is %b expected %b", $time, irq, exp);
        end
    endtask : check_irq

    task automatic check_resp();
        n_tests++;
        if (hresp !== pif_pkg::HRESP_OKAY) begin
            n_fail++;
            $display("MISMATCH at %0t: hresp is %b expected OKAY", $time, hresp);
        end
    endtask : check_resp

    // ========================================
    // Bus and event tasks
    task automatic wait_clk(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_clk

    // Address phase held until hready, then data phase held until hready again
    task automatic ahb_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= pif_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0000_0000;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        check_resp();
    endtask : ahb_xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] dummy;
        ahb_xfer(a, 1'b1, {24'h000000, d}, dummy);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        ahb_xfer(a, 1'b0, 32'h0000_0000, rd);
        check8(rd[7:0], exp, "register read");
    endtask : rd_chk

    // A full rise and fall; the sync chain needs several cycles per level
    task automatic pulse(input int idx);
        @(posedge hclk);
        ev[idx] <= 1'b1;
        wait_clk(4);
        ev[idx] <= 1'b0;
        wait_clk(4);
    endtask : pulse

    // ========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end

    // ========================================
    // Test sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ev = '0;
        wait_clk(8);
        hresetn <= 1'b1;
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::ANALOG_MASK_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_MASK_OFS, 8'h00);
        rd_chk(pif_pkg::ZC_CTRL_OFS, 8'h03);
        wr(12'h020, 8'hff);
        rd_chk(12'h020, 8'h00);
        // Comparator events captured while masked
        pulse(pif_pkg::IN_CMP1);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h01);
        check_irq(1'b0);
        pulse(pif_pkg::IN_CMP2);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h03);
        wait_clk(10);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h03);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'hff);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h43);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        // Zero-cross polarity selection
        wr(pif_pkg::ZC_CTRL_OFS, 8'h00);
        pulse(pif_pkg::IN_ZC);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        wr(pif_pkg::ZC_CTRL_OFS, 8'h01);
        pulse(pif_pkg::IN_ZC);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h40);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        wr(pif_pkg::ZC_CTRL_OFS, 8'h02);
        @(posedge hclk);
        ev[pif_pkg::IN_ZC] <= 1'b1;
        wait_clk(5);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        ev[pif_pkg::IN_ZC] <= 1'b0;
        wait_clk(5);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h40);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        wr(pif_pkg::ZC_CTRL_OFS, 8'h03);
        pulse(pif_pkg::IN_ZC);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h40);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        // Serial flags, with rx and tx following their levels
        pulse(pif_pkg::IN_P1_DONE);
        pulse(pif_pkg::IN_P1_COLL);
        pulse(pif_pkg::IN_P2_DONE);
        pulse(pif_pkg::IN_P2_COLL);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h0f);
        ev[pif_pkg::IN_RX] <= 1'b1;
        ev[pif_pkg::IN_TX] <= 1'b1;
        wait_clk(5);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h3f);
        wr(pif_pkg::SERIAL_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h30);
        wr(pif_pkg::SERIAL_FLAGS_OFS, 8'hff);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h3f);
        ev[pif_pkg::IN_RX] <= 1'b0;
        ev[pif_pkg::IN_TX] <= 1'b0;
        wait_clk(5);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h0f);
        wr(pif_pkg::SERIAL_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h00);
        // Interrupt: clear first, then unmask, raise, mask and clear
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        wr(pif_pkg::ANALOG_MASK_OFS, 8'hff);
        rd_chk(pif_pkg::ANALOG_MASK_OFS, 8'h43);
        wait_clk(3);
        check_irq(1'b0);
        pulse(pif_pkg::IN_CMP1);
        check_irq(1'b1);
        wr(pif_pkg::ANALOG_MASK_OFS, 8'h00);
        wait_clk(3);
        check_irq(1'b0);
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h01);
        wr(pif_pkg::ANALOG_MASK_OFS, 8'h01);
        wait_clk(3);
        check_irq(1'b1);
        wr(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        wait_clk(3);
        check_irq(1'b0);
        wr(pif_pkg::SERIAL_MASK_OFS, 8'h20);
        ev[pif_pkg::IN_RX] <= 1'b1;
        wait_clk(6);
        check_irq(1'b1);
        // Reset in mid-run clears flags and masks
        pulse(pif_pkg::IN_CMP2);
        pulse(pif_pkg::IN_P2_COLL);
        ev[pif_pkg::IN_RX] <= 1'b0;
        hresetn <= 1'b0;
        wait_clk(2);
        check_irq(1'b0);
        hresetn <= 1'b1;
        rd_chk(pif_pkg::ANALOG_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_FLAGS_OFS, 8'h00);
        rd_chk(pif_pkg::SERIAL_MASK_OFS, 8'h00);
        stop_test();
    end
endmodule : tb_top
